// [design/ccsu_pkg.sv]
// Constants, types and register map of the clock source select and update block.
// Function
// - System PLL input selector is 2 bits, reset 0; 0 internal RC, 1 system oscillator.
// - New system PLL selection applies only after update register goes from zero to one.
// - System PLL update register is one bit at position 0, reset 0.
// - USB PLL input selector is 2 bits, reset 0; 0 internal RC, 1 system oscillator.
// - New USB PLL selection applies only after its update register goes from zero to one.
// - USB PLL update register is one bit at position 0, reset 0.
// - Main clock selector is 2 bits, reset 0: RC, PLL input, watchdog, PLL output.
// - New main clock selection applies only after its update register goes from zero to one.
// - Main clock update register is one bit at position 0, reset 0.
// - An update routes the most recently written selector value to its clock output.
// - The main clock reaches core, peripherals and memories through the bus clock divider.
// - Bus clock divider is 8 bits, reset 1; zero stops the clock, else divides.
package ccsu_pkg;

  localparam logic [31:0] ADDR_SYS_SEL  = 32'h40048040;
  localparam logic [31:0] ADDR_SYS_UPD  = 32'h40048044;
  localparam logic [31:0] ADDR_USB_SEL  = 32'h40048048;
  localparam logic [31:0] ADDR_USB_UPD  = 32'h4004804C;
  localparam logic [31:0] ADDR_MAIN_SEL = 32'h40048070;
  localparam logic [31:0] ADDR_MAIN_UPD = 32'h40048074;
  localparam logic [31:0] ADDR_DIV      = 32'h40048078;
  localparam logic [31:0] ADDR_STATUS   = 32'h4004807C;

  localparam int SEL_LSB  = 0;
  localparam int SEL_MSB  = 1;
  localparam int UPD_BIT  = 0;
  localparam int DIV_MSB  = 7;
  localparam int BE_LOW   = 0;
  localparam int ST_BUSY_SYS  = 0;
  localparam int ST_BUSY_USB  = 1;
  localparam int ST_BUSY_MAIN = 2;
  localparam int ST_SYS_LSB   = 4;
  localparam int ST_USB_LSB   = 6;
  localparam int ST_MAIN_LSB  = 8;

  typedef logic [1:0] ccsu_sel_t;
  typedef logic [7:0] ccsu_div_t;

  localparam ccsu_sel_t SRC_IRC         = 2'h0;
  localparam ccsu_sel_t SRC_SYS_OSC     = 2'h1;
  localparam ccsu_sel_t MAIN_SRC_PLL_IN = 2'h1;
  localparam ccsu_sel_t MAIN_SRC_WDT    = 2'h2;
  localparam ccsu_sel_t MAIN_SRC_PLLOUT = 2'h3;
  localparam ccsu_sel_t SEL_RESET       = 2'h0;
  localparam logic      UPD_RESET       = 1'b0;
  localparam ccsu_div_t DIV_RESET       = 8'h01;
  localparam ccsu_div_t DIV_OFF         = 8'h00;
  localparam ccsu_div_t DIV_ONE         = 8'h01;
  localparam logic [31:0] READ_ZERO     = 32'h00000000;

  typedef enum logic [1:0] {MUX_RUN, MUX_DRAIN, MUX_ARM} ccsu_mux_e;

  typedef struct packed {
    ccsu_mux_e st;
    ccsu_sel_t act;
    ccsu_sel_t pend;
    logic      clk;
  } ccsu_mux_s;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [31:0] address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } ccsu_avs_req_s;

  typedef struct packed {
    logic internal_rc_osc;
    logic sys_osc;
    logic wdt_osc;
    logic sys_pll_out;
  } ccsu_src_s;

  typedef struct packed {
    ccsu_sel_t   sys_sel;
    logic        sys_upd;
    ccsu_sel_t   usb_sel;
    logic        usb_upd;
    ccsu_sel_t   main_sel;
    logic        main_upd;
    ccsu_div_t   div;
    ccsu_div_t   cnt;
    ccsu_mux_s   sys_mux;
    ccsu_mux_s   usb_mux;
    ccsu_mux_s   main_mux;
    logic        bus_clk;
    logic        wait_req;
    logic [31:0] rdata;
  } ccsu_state_s;

  localparam ccsu_mux_s MUX_RESET = '{st: MUX_RUN, act: SEL_RESET, pend: SEL_RESET, clk: 1'b0};

  localparam ccsu_state_s STATE_RESET = '{
    sys_sel: SEL_RESET, sys_upd: UPD_RESET, usb_sel: SEL_RESET, usb_upd: UPD_RESET,
    main_sel: SEL_RESET, main_upd: UPD_RESET, div: DIV_RESET, cnt: DIV_OFF,
    sys_mux: MUX_RESET, usb_mux: MUX_RESET, main_mux: MUX_RESET,
    bus_clk: 1'b0, wait_req: 1'b1, rdata: READ_ZERO};

endpackage : ccsu_pkg

// [design/ccsu_top.sv]
// Clock source selectors with zero-then-one update, glitch-free muxes and bus clock divider.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module ccsu_top (
  input  wire logic                   core_clk,
  input  wire logic                   rstn,
  input  wire ccsu_pkg::ccsu_avs_req_s avs_req,
  output logic                        avs_waitrequest,
  output logic [31:0]                 avs_readdata,
  input  wire ccsu_pkg::ccsu_src_s    osc_src,
  output logic                        sys_pll_in_clk,
  output logic                        usb_pll_in_clk,
  output logic                        main_clk,
  output logic                        sys_bus_clk
);

  ccsu_pkg::ccsu_state_s q_reg;
  ccsu_pkg::ccsu_state_s q_next;

  logic                acc;
  logic                wr_take;
  logic                sys_rise;
  logic                usb_rise;
  logic                main_rise;
  logic [3:0]          sys_srcs;
  logic [3:0]          main_srcs;

  // Advance one glitch-free multiplexer. During a drain the output follows the old source until it is low,
  // then is held low until the new source is low too, so no runt pulse can appear.
  function automatic ccsu_pkg::ccsu_mux_s mux_step(input ccsu_pkg::ccsu_mux_s m,
                                                   input logic                upd,
                                                   input ccsu_pkg::ccsu_sel_t sel,
                                                   input logic [3:0]          src);
    ccsu_pkg::ccsu_mux_s r;
    r = m;
    if (upd) begin
      r.pend = sel;
    end
    unique case (m.st)
      ccsu_pkg::MUX_RUN: begin
        r.clk = src[m.act];
        if (r.pend != m.act) begin
          r.st = ccsu_pkg::MUX_DRAIN;
        end
      end
      ccsu_pkg::MUX_DRAIN: begin
        r.clk = src[m.act];
        if (!src[m.act]) begin
          r.clk = 1'b0;
          r.act = r.pend;
          r.st  = ccsu_pkg::MUX_ARM;
        end
      end
      ccsu_pkg::MUX_ARM: begin
        r.clk = 1'b0;
        if (!src[m.act]) begin
          r.st = ccsu_pkg::MUX_RUN;
        end
      end
      default: begin
        r.st  = ccsu_pkg::MUX_RUN;
        r.clk = 1'b0;
      end
    endcase
    return r;
  endfunction : mux_step

  // Word returned for a read; unmapped addresses read as zero.
  function automatic logic [31:0] read_word(input ccsu_pkg::ccsu_state_s s,
                                            input logic [31:0]           a);
    logic [31:0] w;
    w = ccsu_pkg::READ_ZERO;
    unique case (a)
      ccsu_pkg::ADDR_SYS_SEL:  w[ccsu_pkg::SEL_MSB:ccsu_pkg::SEL_LSB] = s.sys_sel;
      ccsu_pkg::ADDR_SYS_UPD:  w[ccsu_pkg::UPD_BIT] = s.sys_upd;
      ccsu_pkg::ADDR_USB_SEL:  w[ccsu_pkg::SEL_MSB:ccsu_pkg::SEL_LSB] = s.usb_sel;
      ccsu_pkg::ADDR_USB_UPD:  w[ccsu_pkg::UPD_BIT] = s.usb_upd;
      ccsu_pkg::ADDR_MAIN_SEL: w[ccsu_pkg::SEL_MSB:ccsu_pkg::SEL_LSB] = s.main_sel;
      ccsu_pkg::ADDR_MAIN_UPD: w[ccsu_pkg::UPD_BIT] = s.main_upd;
      ccsu_pkg::ADDR_DIV:      w[ccsu_pkg::DIV_MSB:0] = s.div;
      ccsu_pkg::ADDR_STATUS: begin
        w[ccsu_pkg::ST_BUSY_SYS]  = (s.sys_mux.st != ccsu_pkg::MUX_RUN);
        w[ccsu_pkg::ST_BUSY_USB]  = (s.usb_mux.st != ccsu_pkg::MUX_RUN);
        w[ccsu_pkg::ST_BUSY_MAIN] = (s.main_mux.st != ccsu_pkg::MUX_RUN);
        w[ccsu_pkg::ST_SYS_LSB +: 2]  = s.sys_mux.act;
        w[ccsu_pkg::ST_USB_LSB +: 2]  = s.usb_mux.act;
        w[ccsu_pkg::ST_MAIN_LSB +: 2] = s.main_mux.act;
      end
      default: w = ccsu_pkg::READ_ZERO;
    endcase
    return w;
  endfunction : read_word

  always_comb begin
    q_next  = q_reg;
    acc     = avs_req.read | avs_req.write;
    // A write lands on the edge where waitrequest is seen low; byte lane 0 holds every field.
    wr_take = avs_req.write & ~q_reg.wait_req & avs_req.byteenable[ccsu_pkg::BE_LOW];
    sys_rise  = 1'b0;
    usb_rise  = 1'b0;
    main_rise = 1'b0;

    // One wait cycle per access, so read data come from registered state.
    q_next.wait_req = ~(acc & q_reg.wait_req);
    if (acc & q_reg.wait_req) begin
      q_next.rdata = read_word(q_reg, avs_req.address);
    end

    if (wr_take) begin
      unique case (avs_req.address)
        ccsu_pkg::ADDR_SYS_SEL: begin
          q_next.sys_sel = avs_req.writedata[ccsu_pkg::SEL_MSB:ccsu_pkg::SEL_LSB];
        end
        ccsu_pkg::ADDR_SYS_UPD: begin
          q_next.sys_upd = avs_req.writedata[ccsu_pkg::UPD_BIT];
          sys_rise = avs_req.writedata[ccsu_pkg::UPD_BIT] & ~q_reg.sys_upd;
        end
        ccsu_pkg::ADDR_USB_SEL: begin
          q_next.usb_sel = avs_req.writedata[ccsu_pkg::SEL_MSB:ccsu_pkg::SEL_LSB];
        end
        ccsu_pkg::ADDR_USB_UPD: begin
          q_next.usb_upd = avs_req.writedata[ccsu_pkg::UPD_BIT];
          usb_rise = avs_req.writedata[ccsu_pkg::UPD_BIT] & ~q_reg.usb_upd;
        end
        ccsu_pkg::ADDR_MAIN_SEL: begin
          q_next.main_sel = avs_req.writedata[ccsu_pkg::SEL_MSB:ccsu_pkg::SEL_LSB];
        end
        ccsu_pkg::ADDR_MAIN_UPD: begin
          q_next.main_upd = avs_req.writedata[ccsu_pkg::UPD_BIT];
          main_rise = avs_req.writedata[ccsu_pkg::UPD_BIT] & ~q_reg.main_upd;
        end
        ccsu_pkg::ADDR_DIV: begin
          q_next.div = avs_req.writedata[ccsu_pkg::DIV_MSB:0];
        end
        default: begin
        end
      endcase
    end

    // Reserved selector codes feed a constant low, so choosing one simply parks the clock.
    sys_srcs  = {1'b0, 1'b0, osc_src.sys_osc, osc_src.internal_rc_osc};
    main_srcs = {osc_src.sys_pll_out, osc_src.wdt_osc, q_reg.sys_mux.clk, osc_src.internal_rc_osc};
    q_next.sys_mux  = mux_step(q_reg.sys_mux, sys_rise, q_reg.sys_sel, sys_srcs);
    q_next.usb_mux  = mux_step(q_reg.usb_mux, usb_rise, q_reg.usb_sel, sys_srcs);
    q_next.main_mux = mux_step(q_reg.main_mux, main_rise, q_reg.main_sel, main_srcs);

    // The divider counts main clock periods on falling edges and passes one whole high
    // phase per period count; a new divisor is compared at once, so a count already past it wraps at the next fall.
    if (q_reg.div == ccsu_pkg::DIV_OFF) begin
      q_next.cnt = ccsu_pkg::DIV_OFF;
    end else if (q_reg.main_mux.clk & ~q_next.main_mux.clk) begin
      if (q_reg.cnt >= q_reg.div - ccsu_pkg::DIV_ONE) begin
        q_next.cnt = ccsu_pkg::DIV_OFF;
      end else begin
        q_next.cnt = q_reg.cnt + ccsu_pkg::DIV_ONE;
      end
    end
    q_next.bus_clk = (q_reg.div != ccsu_pkg::DIV_OFF) & q_next.main_mux.clk
                     & (q_reg.cnt == ccsu_pkg::DIV_OFF);
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      q_reg <= ccsu_pkg::STATE_RESET;
    end else begin
      q_reg <= q_next;
    end
  end

  assign avs_waitrequest = q_reg.wait_req;
  assign avs_readdata    = q_reg.rdata;
  assign sys_pll_in_clk  = q_reg.sys_mux.clk;
  assign usb_pll_in_clk  = q_reg.usb_mux.clk;
  assign main_clk        = q_reg.main_mux.clk;
  assign sys_bus_clk     = q_reg.bus_clk;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  a_reset_values: assert property ($past(!rstn) |-> q_reg.sys_sel == ccsu_pkg::SEL_RESET
      && q_reg.sys_upd == ccsu_pkg::UPD_RESET && q_reg.usb_upd == ccsu_pkg::UPD_RESET
      && q_reg.main_sel == ccsu_pkg::SEL_RESET && q_reg.div == ccsu_pkg::DIV_RESET)
    else $error("Selector, update or divider reset value wrong.");

  a_sys_update_apply: assert property ($rose(q_reg.sys_upd) |-> q_reg.sys_mux.pend == q_reg.sys_sel)
    else $error("System PLL update did not take the written selection.");

  a_sys_hold_pend: assert property (!$rose(q_reg.sys_upd) |-> $stable(q_reg.sys_mux.pend))
    else $error("System PLL selection moved without an update.");

  a_usb_update_apply: assert property ($rose(q_reg.usb_upd) |-> q_reg.usb_mux.pend == q_reg.usb_sel)
    else $error("USB PLL update did not take the written selection.");

  a_main_hold_pend: assert property (!$rose(q_reg.main_upd) |-> $stable(q_reg.main_mux.pend))
    else $error("Main clock selection moved without an update.");

  a_div_stops: assert property (q_reg.div == ccsu_pkg::DIV_OFF |=> !q_reg.bus_clk)
    else $error("Bus clock ran with divider zero.");

  a_div_by_one: assert property (q_reg.div == ccsu_pkg::DIV_ONE && q_reg.cnt == ccsu_pkg::DIV_OFF
      |=> q_reg.bus_clk == q_reg.main_mux.clk)
    else $error("Divide by one does not follow the main clock.");

  a_main_no_runt: assert property ($rose(q_reg.main_mux.clk) |-> $past(q_reg.main_mux.st) == ccsu_pkg::MUX_RUN)
    else $error("Main clock rose while switching.");

  a_arm_held_low: assert property (q_reg.sys_mux.st == ccsu_pkg::MUX_ARM |-> !q_reg.sys_mux.clk)
    else $error("System PLL input clock not held low while arming.");

  a_sys_sel_write: assert property (wr_take
      && avs_req.address == ccsu_pkg::ADDR_SYS_SEL
      |=> q_reg.sys_sel == ccsu_pkg::ccsu_sel_t'($past(avs_req.writedata)))
    else $error("System PLL selector write did not land.");

  a_sys_upd_write: assert property (wr_take
      && avs_req.address == ccsu_pkg::ADDR_SYS_UPD
      |=> q_reg.sys_upd == 1'($past(avs_req.writedata)))
    else $error("System PLL update bit write did not land.");

  a_usb_sel_write: assert property (wr_take
      && avs_req.address == ccsu_pkg::ADDR_USB_SEL
      |=> q_reg.usb_sel == ccsu_pkg::ccsu_sel_t'($past(avs_req.writedata)))
    else $error("USB PLL selector write did not land.");

  a_usb_upd_write: assert property (wr_take
      && avs_req.address == ccsu_pkg::ADDR_USB_UPD
      |=> q_reg.usb_upd == 1'($past(avs_req.writedata)))
    else $error("USB PLL update bit write did not land.");

  a_main_sel_write: assert property (wr_take
      && avs_req.address == ccsu_pkg::ADDR_MAIN_SEL
      |=> q_reg.main_sel == ccsu_pkg::ccsu_sel_t'($past(avs_req.writedata)))
    else $error("Main clock selector write did not land.");

  a_main_upd_write: assert property (wr_take
      && avs_req.address == ccsu_pkg::ADDR_MAIN_UPD
      |=> q_reg.main_upd == 1'($past(avs_req.writedata)))
    else $error("Main clock update bit write did not land.");

  a_div_write: assert property (wr_take
      && avs_req.address == ccsu_pkg::ADDR_DIV
      |=> q_reg.div == ccsu_pkg::ccsu_div_t'($past(avs_req.writedata)))
    else $error("Divider write did not land.");

  a_sys_read_back: assert property (avs_req.read && q_reg.wait_req
      && avs_req.address == ccsu_pkg::ADDR_SYS_SEL
      |=> q_reg.rdata == 32'($past(q_reg.sys_sel)))
    else $error("System PLL selector read back wrong.");

  a_sys_upd_read: assert property (avs_req.read && q_reg.wait_req
      && avs_req.address == ccsu_pkg::ADDR_SYS_UPD
      |=> q_reg.rdata == 32'($past(q_reg.sys_upd)))
    else $error("System PLL update bit read back wrong.");

  a_usb_read_back: assert property (avs_req.read && q_reg.wait_req
      && avs_req.address == ccsu_pkg::ADDR_USB_SEL
      |=> q_reg.rdata == 32'($past(q_reg.usb_sel)))
    else $error("USB PLL selector read back wrong.");

  a_usb_upd_read: assert property (avs_req.read && q_reg.wait_req
      && avs_req.address == ccsu_pkg::ADDR_USB_UPD
      |=> q_reg.rdata == 32'($past(q_reg.usb_upd)))
    else $error("USB PLL update bit read back wrong.");

  a_main_read_back: assert property (avs_req.read && q_reg.wait_req
      && avs_req.address == ccsu_pkg::ADDR_MAIN_SEL
      |=> q_reg.rdata == 32'($past(q_reg.main_sel)))
    else $error("Main clock selector read back wrong.");

  a_main_upd_read: assert property (avs_req.read && q_reg.wait_req
      && avs_req.address == ccsu_pkg::ADDR_MAIN_UPD
      |=> q_reg.rdata == 32'($past(q_reg.main_upd)))
    else $error("Main clock update bit read back wrong.");

  a_div_read_back: assert property (avs_req.read && q_reg.wait_req
      && avs_req.address == ccsu_pkg::ADDR_DIV
      |=> q_reg.rdata == 32'($past(q_reg.div)))
    else $error("Divider read back wrong.");

  a_usb_hold_pend: assert property (!$rose(q_reg.usb_upd)
      |->
      $stable(q_reg.usb_mux.pend))
    else $error("USB PLL selection moved without an update.");

  a_main_update_apply: assert property ($rose(q_reg.main_upd)
      |->
      q_reg.main_mux.pend == q_reg.main_sel)
    else $error("Main clock update did not take the written selection.");

  a_sys_no_runt: assert property ($rose(q_reg.sys_mux.clk)
      |->
      $past(q_reg.sys_mux.st) == ccsu_pkg::MUX_RUN)
    else $error("System PLL input clock rose while switching.");

  a_usb_no_runt: assert property ($rose(q_reg.usb_mux.clk)
      |->
      $past(q_reg.usb_mux.st) == ccsu_pkg::MUX_RUN)
    else $error("USB PLL input clock rose while switching.");

  a_usb_arm_low: assert property (q_reg.usb_mux.st == ccsu_pkg::MUX_ARM
      |->
      !q_reg.usb_mux.clk)
    else $error("USB PLL input clock not held low while arming.");

  a_main_arm_low: assert property (q_reg.main_mux.st == ccsu_pkg::MUX_ARM
      |->
      !q_reg.main_mux.clk)
    else $error("Main clock not held low while arming.");

  a_sys_drain_start: assert property (q_reg.sys_mux.st == ccsu_pkg::MUX_RUN
      && q_reg.sys_mux.pend != q_reg.sys_mux.act
      |=> q_reg.sys_mux.st == ccsu_pkg::MUX_DRAIN)
    else $error("System PLL mux did not start draining.");

  a_main_drain_start: assert property (q_reg.main_mux.st == ccsu_pkg::MUX_RUN
      && q_reg.main_mux.pend != q_reg.main_mux.act
      |=> q_reg.main_mux.st == ccsu_pkg::MUX_DRAIN)
    else $error("Main clock mux did not start draining.");

  a_bus_in_main: assert property (q_reg.bus_clk
      |->
      q_reg.main_mux.clk)
    else $error("Bus clock high outside a main clock high phase.");

  a_div_off_count: assert property (q_reg.div == ccsu_pkg::DIV_OFF
      |=>
      q_reg.cnt == ccsu_pkg::DIV_OFF)
    else $error("Divider count ran while the bus clock is stopped.");

  a_reset_clocks: assert property ($past(!rstn)
      |->
      !q_reg.bus_clk && !q_reg.main_mux.clk && q_reg.wait_req)
    else $error("Clock or waitrequest output wrong after reset.");

  c_main_switch: cover property (q_reg.main_mux.st == ccsu_pkg::MUX_DRAIN ##[1:50]
                                 q_reg.main_mux.st == ccsu_pkg::MUX_RUN);
  c_usb_to_osc: cover property ($rose(q_reg.usb_upd) && q_reg.usb_sel == ccsu_pkg::SRC_SYS_OSC);
  c_div_stop: cover property (q_reg.div == ccsu_pkg::DIV_OFF);
  c_sys_switch: cover property ($rose(q_reg.sys_upd));
  c_bus_rise: cover property ($rose(q_reg.bus_clk));

endmodule : ccsu_top

// [verif/tb.sv]
// Register-level self-checking testbench of the clock source select and update block.
`timescale 1ns/1ps
module tb;
  logic                    core_clk = 1'b0;
  logic                    rstn     = 1'b0;
  ccsu_pkg::ccsu_avs_req_s req      = '0;
  ccsu_pkg::ccsu_src_s     osc_src  = '0;
  ccsu_pkg::ccsu_src_s     src_d    = '0;
  logic                    sys_in_d = 1'b0;
  logic                    avs_waitrequest;
  logic                    sys_pll_in_clk;
  logic                    usb_pll_in_clk;
  logic                    main_clk;
  logic                    sys_bus_clk;
  logic [31:0]             avs_readdata;
  logic [31:0]             rd;
  int                      miscompares = 0;
  int                      compares    = 0;
  int                      cyc         = 0;
  int                      hi_run      = 0;
  int                      gap;
  int                      br;
  logic [31:0]             rst_addr [9];
  logic [31:0]             rst_exp  [9];
  logic [1:0]              codes    [4];
  logic [7:0]              divs     [4];

  always #20 core_clk = ~core_clk;

  ccsu_top dut_u (.core_clk(core_clk), .rstn(rstn), .avs_req(req), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .osc_src(osc_src), .sys_pll_in_clk(sys_pll_in_clk),
    .usb_pll_in_clk(usb_pll_in_clk), .main_clk(main_clk), .sys_bus_clk(sys_bus_clk));

  // Sources keep half periods of three cycles or more, so the sampling muxes never alias them.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    osc_src.internal_rc_osc <= (cyc % 6) < 3;
    osc_src.sys_osc <= (cyc % 10) < 5;
    osc_src.wdt_osc <= (cyc % 14) < 7;
    osc_src.sys_pll_out <= (cyc % 8) < 4;
    src_d <= osc_src;
    sys_in_d <= sys_pll_in_clk;
    if (rstn && cyc > 100 && !main_clk && hi_run != 0) check("main high width", 32'(hi_run >= 3), 32'h1);
    hi_run <= main_clk ? hi_run + 1 : 0;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic to_fail;
    miscompares++;
    tally_and_finish();
  endtask : to_fail

  task automatic avs(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge core_clk);
    req.read <= !wr;
    req.write <= wr;
    req.address <= a;
    req.writedata <= d;
    req.byteenable <= be;
    // Waitrequest and read data are sampled at the very edge that completes the access.
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) to_fail();
    rd = avs_readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask : avs

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    avs(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    avs(1'b0, a, 32'h0, 4'hF);
    check(nm, rd, exp);
  endtask : rdchk

  // Leaves the final status word in rd once the mux reports it is no longer busy.
  task automatic upd(input logic [31:0] sa, input logic [31:0] ua, input logic [1:0] v, input int busy);
    int n;
    n = 0;
    wr(sa, 32'(v));
    wr(ua, 32'h0);
    wr(ua, 32'h1);
    do begin
      avs(1'b0, ccsu_pkg::ADDR_STATUS, 32'h0, 4'hF);
      n++;
    end while (rd[busy] !== 1'b0 && n < 60);
    if (n >= 60) to_fail();
  endtask : upd

  task automatic follow(input int w, input logic [1:0] c);
    logic e;
    logic g;
    repeat (24) begin
      @(posedge core_clk);
      #1;
      g = w == 0 ? sys_pll_in_clk : w == 1 ? usb_pll_in_clk : main_clk;
      e = c == 2'h0 ? src_d.internal_rc_osc : c == 2'h2 ? src_d.wdt_osc : c == 2'h3 ? src_d.sys_pll_out :
          w == 2 ? sys_in_d : src_d.sys_osc;
      check("clock output", 32'(g), 32'(e));
    end
  endtask : follow

  // Counts main clock rises between the last two of four bus clock rises.
  task automatic div_gap(input logic [7:0] dv, output int gp, output int bn);
    int   n;
    int   mr;
    logic mp;
    logic bp;
    n = 0;
    mr = 0;
    bn = 0;
    gp = 0;
    wr(ccsu_pkg::ADDR_DIV, 32'(dv));
    mp = main_clk;
    bp = sys_bus_clk;
    while (bn < 4 && n < 8000) begin
      @(posedge core_clk);
      #1;
      n++;
      if (main_clk && !mp) mr++;
      if (sys_bus_clk && !bp) begin
        bn++;
        gp = mr;
        mr = 0;
      end
      mp = main_clk;
      bp = sys_bus_clk;
    end
  endtask : div_gap

  initial begin
    rst_addr = '{ccsu_pkg::ADDR_SYS_SEL, ccsu_pkg::ADDR_SYS_UPD, ccsu_pkg::ADDR_USB_SEL, ccsu_pkg::ADDR_USB_UPD,
                 ccsu_pkg::ADDR_MAIN_SEL, ccsu_pkg::ADDR_MAIN_UPD, ccsu_pkg::ADDR_DIV, ccsu_pkg::ADDR_STATUS,
                 32'h40048050};
    rst_exp = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
    codes = '{2'h1, 2'h2, 2'h3, 2'h0};
    divs = '{8'h01, 8'h03, 8'hFF, 8'h00};
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 9; i++) rdchk("reset value", rst_addr[i], rst_exp[i]);
    wr(ccsu_pkg::ADDR_SYS_SEL, 32'hFFFFFFFD);
    rdchk("sys select", ccsu_pkg::ADDR_SYS_SEL, 32'h1);
    rdchk("sys not applied", ccsu_pkg::ADDR_STATUS, 32'h0);
    upd(ccsu_pkg::ADDR_SYS_SEL, ccsu_pkg::ADDR_SYS_UPD, 2'h1, ccsu_pkg::ST_BUSY_SYS);
    check("sys active", 32'(rd[ccsu_pkg::ST_SYS_LSB +: 2]), 32'h1);
    follow(0, 2'h1);
    rdchk("sys update bit", ccsu_pkg::ADDR_SYS_UPD, 32'h1);
    wr(ccsu_pkg::ADDR_SYS_SEL, 32'h0);
    wr(ccsu_pkg::ADDR_SYS_UPD, 32'h1);
    avs(1'b0, ccsu_pkg::ADDR_STATUS, 32'h0, 4'hF);
    check("sys one without zero", 32'(rd[ccsu_pkg::ST_SYS_LSB +: 2]), 32'h1);
    wr(ccsu_pkg::ADDR_USB_SEL, 32'h1);
    rdchk("usb not applied", ccsu_pkg::ADDR_STATUS, 32'h10);
    upd(ccsu_pkg::ADDR_USB_SEL, ccsu_pkg::ADDR_USB_UPD, 2'h1, ccsu_pkg::ST_BUSY_USB);
    check("usb active", 32'(rd[ccsu_pkg::ST_USB_LSB +: 2]), 32'h1);
    follow(1, 2'h1);
    rdchk("usb update bit", ccsu_pkg::ADDR_USB_UPD, 32'h1);
    foreach (codes[i]) begin
      upd(ccsu_pkg::ADDR_MAIN_SEL, ccsu_pkg::ADDR_MAIN_UPD, codes[i], ccsu_pkg::ST_BUSY_MAIN);
      check("main active", 32'(rd[ccsu_pkg::ST_MAIN_LSB +: 2]), 32'(codes[i]));
      follow(2, codes[i]);
    end
    rdchk("main update bit", ccsu_pkg::ADDR_MAIN_UPD, 32'h1);
    foreach (divs[i]) begin
      div_gap(divs[i], gap, br);
      check("bus rises", 32'(br), divs[i] == 8'h00 ? 32'h0 : 32'h4);
      check("main per bus", 32'(gap), 32'(divs[i]));
    end
    check("bus stopped", 32'(sys_bus_clk), 32'h0);
    avs(1'b1, ccsu_pkg::ADDR_DIV, 32'h7, 4'hE);
    rdchk("divider kept", ccsu_pkg::ADDR_DIV, 32'h0);
    tally_and_finish();
  end
endmodule : tb
